/* File: hw/pcc_clock_ctrl.sv */
// Clock controller: oscillator sync, PLL, gating, Wishbone registers
`timescale 1ns/1ps
module pcc_clock_ctrl #(
    parameter int unsigned LOCK_EDGES = pcc_pkg::LOCK_REF_EDGES
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Oscillator pins
    input  wire logic        osc_input_pin_i,
    output logic             osc_output_pin_o,
    output logic             osc_inv_en_o,
    // Clock enables and PLL lock
    output logic             cpu_clk_en_o,
    output logic             periph_clk_en_o,
    output logic             usb_clk_en_o,
    output logic [3:0]       derived_clk_en_o,
    output logic             pll_lock_o
);
    import pcc_pkg::*;

    // Lock counter in the synthesiser is 16 bits wide
    if (LOCK_EDGES < 1 || LOCK_EDGES > 65535) begin : g_bad_lock
        $error("LOCK_EDGES out of range");
    end

    typedef struct packed {
        logic        sy1;
        logic        sy2;
        logic        sy3;
        logic        lvl;
        logic        refe;
        logic [15:0] ctrl;
        logic [7:0]  div;
        logic        ack;
        logic [31:0] dat;
        logic        cpu;
        logic        per;
        logic        usb;
        logic [3:0]  drv;
        logic        xout;
    } pcc_top_st_type;

    pcc_top_st_type q;
    pcc_top_st_type n;

    pcc_pll_if pll_if ();

    logic        pll_en;
    logic        usb_sel;
    logic        cpu_sel;
    logic        ext_mode;
    logic        inv_en;
    logic        osc_live;
    logic        cpu_src;
    logic        usb_src;
    logic        wb_req;
    pcc_pwr_type pwr;
    logic [31:0] rdata;

    assign pll_en   = q.ctrl[CTRL_PLL_EN];
    assign usb_sel  = q.ctrl[CTRL_USB_PLL];
    assign cpu_sel  = q.ctrl[CTRL_CPU_PLL];
    assign ext_mode = q.ctrl[CTRL_EXT_CLK];
    assign pwr      = pcc_pwr_type'(q.ctrl[CTRL_PWR_LO +: 2]);

    // Inverter runs only while PLL feeds USB
    assign inv_en   = usb_sel & ~ext_mode; // R6
    // Edges usable from crystal or external clock
    assign osc_live = ext_mode | inv_en; // R4 R5

    assign pll_if.ref_tick = q.refe;
    assign pll_if.run      = pll_en & osc_live;
    assign pll_if.mult     = {1'b0, q.div[DIV_R_LO +: 4]} + 5'h01; // R9
    assign pll_if.divn     = {1'b0, q.div[DIV_N_LO +: 4]} + 5'h01; // R9

    pcc_pll_synth #(
        .LOCK_EDGES (LOCK_EDGES)
    ) u_synth (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pll   (pll_if.syn)
    );

    // Core and peripherals stay on oscillator until lock
    assign cpu_src = (cpu_sel & pll_if.lock) ? pll_if.out_tick : q.refe; // R1
    assign usb_src = usb_sel & pll_if.lock & pll_if.out_tick; // R1
    assign wb_req  = wb_cyc_i & wb_stb_i & ~q.ack;

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            ADR_CTRL: rdata[15:0] = q.ctrl;
            ADR_DIV:  rdata[7:0]  = q.div;
            ADR_STAT: begin
                rdata[STAT_LOCK]          = pll_if.lock;
                rdata[STAT_OSC_ON]        = osc_live;
                rdata[STAT_PLL_RUN]       = pll_if.run;
                rdata[STAT_PWR_LO +: 2]   = q.ctrl[CTRL_PWR_LO +: 2];
            end
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_comb begin
        n     = q;
        n.sy1 = osc_input_pin_i;
        n.sy2 = q.sy1;
        n.sy3 = q.sy2;
        // Level counts once two stages agree
        if (q.sy2 == q.sy3) begin
            n.lvl = q.sy3;
        end
        n.refe = n.lvl & ~q.lvl & osc_live; // R4 R5
        n.xout = inv_en & ~q.lvl; // R6

        n.cpu = 1'b0;
        n.per = 1'b0;
        n.usb = 1'b0;
        unique case (pwr)
            PWR_RUN: begin
                n.cpu = cpu_src; // R1 R3
                n.per = cpu_src; // R1 R3
                n.usb = usb_src; // R1 R3
            end
            PWR_IDLE: begin
                n.per = cpu_src; // R3
                n.usb = usb_src; // R3
            end
            PWR_DOWN: begin
                n.cpu = 1'b0; // R3
            end
            default: begin
                n.cpu = 1'b0;
            end
        endcase
        // Per-peripheral ticks follow peripheral clock
        n.drv = {4{n.per}} & q.ctrl[CTRL_DRV_LO +: 4]; // R2

        n.ack = wb_req;
        if (wb_req) begin
            n.dat = rdata;
            if (wb_we_i) begin
                if (wb_adr_i == ADR_CTRL) begin
                    if (wb_sel_i[0]) begin
                        n.ctrl[7:0] = wb_dat_i[7:0] & CTRL_MASK[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        n.ctrl[15:8] = wb_dat_i[15:8] & CTRL_MASK[15:8];
                    end
                end
                if (wb_adr_i == ADR_DIV && wb_sel_i[0]) begin
                    n.div = wb_dat_i[7:0];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q      <= '0;
            q.ctrl <= CTRL_RST;
            q.div  <= DIV_RST;
        end else begin
            q <= n;
        end
    end

    assign wb_ack_o         = q.ack;
    assign wb_dat_o         = q.dat;
    assign osc_output_pin_o = q.xout;
    assign osc_inv_en_o     = inv_en;
    assign cpu_clk_en_o     = q.cpu;
    assign periph_clk_en_o  = q.per;
    assign usb_clk_en_o     = q.usb;
    assign derived_clk_en_o = q.drv;
    assign pll_lock_o       = pll_if.lock;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    chk_idle_cpu_off: assert property (pwr == PWR_IDLE |=> !cpu_clk_en_o) // R3
        else $error("core clock ran in idle");
    chk_down_all_off: assert property (
        pwr == PWR_DOWN |=> !(cpu_clk_en_o || periph_clk_en_o || usb_clk_en_o)) // R3
        else $error("clock ran in power down");
    chk_usb_from_pll: assert property (
        usb_clk_en_o |-> $past(pll_if.lock) && $past(usb_sel) && $past(pll_if.out_tick)) // R1
        else $error("usb tick without locked pll");
    chk_cpu_from_osc: assert property (
        pwr == PWR_RUN && !cpu_sel && q.refe |=> cpu_clk_en_o && periph_clk_en_o) // R1
        else $error("oscillator edge lost on core clock");
    chk_inv_off_quiet: assert property (
        !osc_inv_en_o && !ext_mode |=> !q.refe && !osc_output_pin_o) // R6
        else $error("oscillator active with inverter off");
    chk_derived_periph: assert property (derived_clk_en_o != 4'h0 |-> periph_clk_en_o) // R2
        else $error("derived tick without peripheral tick");
    chk_ext_edge: assert property ($rose(q.lvl) && $past(ext_mode) |-> q.refe) // R4
        else $error("external clock edge dropped");
    chk_xtal_edge: assert property ($rose(q.lvl) && $past(inv_en) |-> q.refe) // R5
        else $error("crystal edge dropped");

    // Register updates and read-back
    chk_ctrl_write: assert property (
        wb_req && wb_we_i && wb_adr_i == ADR_CTRL && wb_sel_i == 4'hF
        |=> q.ctrl == ($past(wb_dat_i[15:0]) & CTRL_MASK)) // R3
        else $error("control write not applied");
    chk_div_write: assert property (
        wb_req && wb_we_i && wb_adr_i == ADR_DIV && wb_sel_i[0]
        |=> q.div == $past(wb_dat_i[7:0])) // R9
        else $error("divider write not applied");
    chk_div_read: assert property (
        wb_req && !wb_we_i && wb_adr_i == ADR_DIV |=> wb_dat_o[7:0] == $past(q.div)) // R9
        else $error("divider read-back wrong");
    // Clock sources and gating
    chk_usb_sel_off: assert property (!usb_sel |=> !usb_clk_en_o) // R1
        else $error("usb tick without pll selected");
    chk_drv_masked: assert property (
        (derived_clk_en_o & ~$past(q.ctrl[CTRL_DRV_LO +: 4])) == 4'h0) // R2
        else $error("derived tick while disabled");
    chk_ext_inv_off: assert property (ext_mode |-> !osc_inv_en_o) // R6
        else $error("inverter on with external clock");
    chk_lock_run: assert property (pll_if.lock |-> $past(pll_if.run)) // R9
        else $error("lock without running pll");
    chk_run_down: assert property (pwr == PWR_DOWN |=> !derived_clk_en_o[DRV_TIMER]) // R2 R3
        else $error("timer tick in power down");

    cov_usb_tick: cover property (usb_clk_en_o);
    cov_idle_periph: cover property (pwr == PWR_IDLE && periph_clk_en_o);
    cov_cpu_on_pll: cover property (cpu_sel && pll_if.lock && cpu_clk_en_o);
    cov_div_write: cover property (wb_req && wb_we_i && wb_adr_i == ADR_DIV);
endmodule

/* File: hw/pcc_pll_synth.sv */
// Ratio synthesiser with lock counter
`timescale 1ns/1ps
module pcc_pll_synth #(
    parameter int unsigned LOCK_EDGES = pcc_pkg::LOCK_REF_EDGES
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Controller side
    pcc_pll_if.syn    pll
);
    import pcc_pkg::*;

    if (LOCK_EDGES < 1 || LOCK_EDGES > 65535) begin : g_bad_lock
        $error("LOCK_EDGES out of range");
    end

    typedef struct packed {
        logic [7:0]  acc;
        logic [15:0] lcnt;
        logic        lock;
        logic        tick;
        logic [9:0]  cfg;
    } pcc_syn_st_type;

    pcc_syn_st_type q;
    pcc_syn_st_type n;
    logic [8:0]     sum;

    always_comb begin
        n      = q;
        n.tick = 1'b0;
        n.cfg  = {pll.mult, pll.divn};
        sum    = {1'b0, q.acc} + (pll.ref_tick ? {4'h0, pll.mult} : 9'h000);
        if (!pll.run || n.cfg != q.cfg) begin
            n.acc  = 8'h00;
            n.lcnt = 16'h0000;
            n.lock = 1'b0;
        end else begin
            // Add R+1 per reference edge, emit per N+1
            if (sum >= {4'h0, pll.divn}) begin // R9
                n.tick = 1'b1;
                sum    = sum - {4'h0, pll.divn};
            end
            n.acc = (sum > 9'h0FF) ? 8'hFF : sum[7:0];
            if (pll.ref_tick && !q.lock) begin
                if (q.lcnt == 16'(LOCK_EDGES - 1)) begin
                    n.lock = 1'b1;
                end else begin
                    n.lcnt = q.lcnt + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign pll.out_tick = q.tick;
    assign pll.lock     = q.lock;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_stop_no_tick: assert property (!pll.run |=> !pll.out_tick) // R9
        else $error("synth ticked while stopped");
    chk_stop_unlock: assert property (!pll.run |=> !pll.lock) // R9
        else $error("lock held while stopped");
    chk_lock_count: assert property ($rose(pll.lock) |-> $past(q.lcnt) == 16'(LOCK_EDGES - 1)) // R9
        else $error("lock rose at wrong edge count");
    chk_cfg_relock: assert property (pll.run && n.cfg != q.cfg |=> !pll.lock) // R9
        else $error("divider change kept lock");
    cov_lock: cover property ($rose(pll.lock));
endmodule

/* File: pkg/pcc_pkg.sv */
// Constants and types of the clock controller
// Behaviour
// (R1) Three clocks: core, peripherals, USB, from oscillator/PLL
// (R2) Timer, counter-array, watchdog, port ticks from peripheral
// (R3) Power mode gates each output clock
// (R4) Input pin accepts external 48 MHz clock
// (R5) Crystal across pins runs up to 32 MHz
// (R6) Inverter off unless PLL feeds USB
// (R7) Software waits for lock before trusting clock
// (R8) Software sets divider byte for 48 MHz
// (R9) Output equals input times (R+1)/(N+1)
package pcc_pkg;
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned EXT_CLK_MHZ   = 48;
    localparam int unsigned XTAL_MAX_MHZ  = 32;
    localparam int unsigned LOCK_REF_EDGES = 64;

    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_DIV  = 8'h04;
    localparam logic [7:0] ADR_STAT = 8'h08;

    localparam int unsigned CTRL_PLL_EN  = 0;
    localparam int unsigned CTRL_USB_PLL = 1;
    localparam int unsigned CTRL_CPU_PLL = 2;
    localparam int unsigned CTRL_PWR_LO  = 3;
    localparam int unsigned CTRL_EXT_CLK = 5;
    localparam int unsigned CTRL_DRV_LO  = 8;
    localparam logic [15:0] CTRL_MASK    = 16'h0F3F;
    localparam logic [15:0] CTRL_RST     = 16'h0F00;
    localparam logic [7:0]  DIV_RST      = 8'h00;

    localparam int unsigned DIV_N_LO = 0;
    localparam int unsigned DIV_R_LO = 4;

    localparam int unsigned STAT_LOCK    = 0;
    localparam int unsigned STAT_OSC_ON  = 1;
    localparam int unsigned STAT_PLL_RUN = 2;
    localparam int unsigned STAT_PWR_LO  = 3;

    localparam int unsigned DRV_TIMER = 0;
    localparam int unsigned DRV_PCA   = 1;
    localparam int unsigned DRV_WDT   = 2;
    localparam int unsigned DRV_PORT  = 3;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_IDLE,
        PWR_DOWN
    } pcc_pwr_type;
endpackage

/* File: pkg/pcc_pll_if.sv */
// Link between controller and frequency synthesiser
`timescale 1ns/1ps
interface pcc_pll_if;
    logic       ref_tick;
    logic       run;
    logic [4:0] mult;
    logic [4:0] divn;
    logic       out_tick;
    logic       lock;
    modport ctl (output ref_tick, run, mult, divn, input out_tick, lock);
    modport syn (input ref_tick, run, mult, divn, output out_tick, lock);
endinterface

/* File: tb/pcc_osc_model.sv */
// Oscillator source model driving the input pin
`timescale 1ns/1ps
module pcc_osc_model (
    // Clock and control
    input  wire logic       clk_i,
    input  wire logic       run_i,
    input  wire logic [3:0] half_i,
    // Oscillator pin
    output logic            osc_input_pin_o
);
    logic [3:0] cnt_q = 4'h0;
    initial osc_input_pin_o = 1'b0;
    // Toggles each half_i cycles, rests low when stopped
    always @(posedge clk_i) begin
        if (!run_i) begin
            cnt_q <= 4'h0;
            osc_input_pin_o <= 1'b0;
        end else if (cnt_q + 4'h1 >= half_i) begin
            cnt_q <= 4'h0;
            osc_input_pin_o <= ~osc_input_pin_o;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

/* File: tb/tb_pcc_clock_ctrl.sv */
// Self-checking bench of the clock controller
`timescale 1ns/1ps
module tb_pcc_clock_ctrl;
    import pcc_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rd, rdat;
    logic ack, pin, opin, inv, cpu, per, usb, lock;
    logic [3:0] drv;
    int error_cnt = 0, total_checks = 0, n_cpu, n_per, n_usb, n_drv, n_ref;
    pcc_osc_model u_pcc_osc_model (.clk_i(clk_i), .run_i(run), .half_i(4'h4),
        .osc_input_pin_o(pin));
    pcc_clock_ctrl #(.LOCK_EDGES(4)) u_pcc_clock_ctrl (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .osc_input_pin_i(pin),
        .osc_output_pin_o(opin), .osc_inv_en_o(inv), .cpu_clk_en_o(cpu),
        .periph_clk_en_o(per), .usb_clk_en_o(usb), .derived_clk_en_o(drv), .pll_lock_o(lock));
    initial forever #25 clk_i = ~clk_i;
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (e !== g) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic near(input string nm, input int e, input int g, input int tol);
        total_checks++;
        if (g < e - tol || g > e + tol) begin
            error_cnt++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (k >= 20) chk("wb_ack", 1, 0);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(negedge clk_i);
    endtask
    task automatic measure(input int n);
        {n_cpu, n_per, n_usb, n_drv, n_ref} = '0;
        repeat (n) begin
            @(negedge clk_i);
            n_cpu += (cpu === 1'b1);
            n_per += (per === 1'b1);
            n_usb += (usb === 1'b1);
            n_drv += $countones(drv);
            n_ref += (pin && !u_pcc_osc_model.cnt_q && run);
        end
    endtask
    task automatic t_regs;
        wb(0, ADR_CTRL, 0);
        chk("ctrl", 32'h0F00, rd);
        wb(0, ADR_DIV, 0);
        chk("div", 32'h0, rd);
        wb(1, ADR_STAT, 32'hFF);
        wb(0, ADR_STAT, 0);
        chk("stat", 32'h0, rd);
        wb(0, 8'h0C, 0);
        chk("unmapped", 32'h0, rd);
    endtask
    task automatic t_inv;
        wb(1, ADR_CTRL, 32'h0F02);
        chk("inv_usb", 1, inv);
        chk("opin_on", 1, opin);
        wb(1, ADR_CTRL, 32'h0F22);
        chk("inv_ext", 0, inv);
        wb(1, ADR_CTRL, 32'h0F00);
        chk("inv_off", 0, inv);
        chk("opin_off", 0, opin);
    endtask
    task automatic t_gate;
        @(posedge clk_i);
        run <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            wb(1, ADR_CTRL, 32'h0F20 | (p << 3));
            measure(80);
            near("cpu", (p == 0) ? n_ref : 0, n_cpu, 1);
            near("per", (p < 2) ? n_ref : 0, n_per, 1);
            chk("drv", 4 * n_per, n_drv);
            chk("usb", 0, n_usb);
        end
    endtask
    task automatic t_pll(input logic [7:0] dv, input int r1, input int n1);
        int k;
        wb(1, ADR_DIV, dv);
        chk("lock_clear", 0, lock);
        k = 0;
        while (lock !== 1'b1 && k < 300) begin
            @(negedge clk_i);
            k++;
        end
        chk("lock", 1, lock);
        wb(0, ADR_STAT, 0);
        chk("stat_lock", 1, rd[STAT_LOCK]);
        measure(160);
        near("usb_ratio", n_ref * r1 / n1, n_usb, r1 + 1);
        near("cpu_pll", n_usb, n_cpu, r1 + 1);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk("lock_rst", 0, lock);
        t_regs;
        t_inv;
        t_gate;
        wb(1, ADR_CTRL, 32'h0F27);
        t_pll(8'h30, 4, 1);
        t_pll(8'h21, 3, 2);
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        complete_run;
    end
endmodule
